// ---- core/mmu_pkg.sv ----
// Shared types and constants of the translation unit
package mmu_pkg;

  // Geometry
  localparam int WAYS     = 4;
  localparam int SETS     = 16;
  localparam int IDX_W    = 4;
  localparam int TAG_W    = 16;
  localparam int PA_W     = 20;
  localparam int OFF_W    = 12;
  localparam int IDX4K_LO = 12;
  localparam int IDX8K_LO = 13;
  localparam int TAG_LO   = 16;
  localparam int LA12     = 12;

  // Cache mode encodings
  typedef enum logic [1:0] {
    CM_WT     = 2'b00,
    CM_CB     = 2'b01,
    CM_NC_SER = 2'b10,
    CM_NC     = 2'b11
  } cache_mode_e;

  // Control flow states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WALK = 1'b1
  } state_e;

  // One translation cache entry: tag then attributes then address
  typedef struct packed {
    logic              valid;
    logic              is_global;
    logic              privilege_tag_bit;
    logic [TAG_W-1:0]  la_tag;
    logic              user_attr_bit1;
    logic              user_attr_bit0;
    logic              s;
    cache_mode_e       cache_mode_field;
    logic              m;
    logic              w;
    logic              r;
    logic [PA_W-1:0]   pa;
  } entry_s;

  // Access from a memory unit
  typedef struct packed {
    logic [31:0] la;
    logic        supervisor;
    logic        write;
    logic        rmw;
  } req_s;

  // Answer to a memory unit and the cache controller
  typedef struct packed {
    logic        valid;
    logic        ok;
    logic        retry;
    logic        fault;
    logic        transparent;
    logic [31:0] pa;
    cache_mode_e cm;
  } resp_s;

  // Result of a table search
  typedef struct packed {
    logic [PA_W-1:0] pa;
    logic            u1;
    logic            u0;
    logic            s;
    cache_mode_e     cm;
    logic            m;
    logic            w;
    logic            g;
    logic            nonres;
    logic            terr;
  } desc_s;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WIN0 = 8'h04;
  localparam logic [7:0] ADDR_WIN1 = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [31:0] RST_REG  = 32'h0000_0000;

  // Control and status bits
  localparam int CTRL_EN   = 0;
  localparam int CTRL_PG8K = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FLT  = 1;
  localparam int STAT_MISS = 2;
  localparam int STAT_CNT  = 4;

  // Window register fields
  localparam int WIN_BASE_LO = 24;
  localparam int WIN_MASK_LO = 16;
  localparam int WIN_EN      = 15;
  localparam int WIN_S_LO    = 13;
  localparam int WIN_U_LO    = 8;
  localparam int WIN_CM_LO   = 5;
  localparam int WIN_WP      = 2;

  // Privilege select codes of a window
  localparam logic [1:0] SEL_USER  = 2'b00;
  localparam logic [1:0] SEL_SUPER = 2'b01;

endpackage

// ---- core/window_match.sv ----
// Match logic of one transparent translation window
`timescale 1ns/1ns
module window_match
  import mmu_pkg::*;
(
  // Access
  input  logic [31:0] la,
  input  logic        supervisor,
  // Window register contents
  input  logic [31:0] win,
  // Result
  output logic        hit
);

  logic [7:0] base;
  logic [7:0] mask;
  logic [1:0] sel;
  logic       priv_ok;

  // Field extraction
  assign base = win[WIN_BASE_LO +: 8];
  assign mask = win[WIN_MASK_LO +: 8];
  assign sel  = win[WIN_S_LO +: 2];

  // Privilege select: user only, supervisor only, or both
  assign priv_ok = (sel == SEL_USER)  ? !supervisor :
                   (sel == SEL_SUPER) ? supervisor : 1'b1;

  // Disabled window is ignored; masked positions never compare
  assign hit = win[WIN_EN] && priv_ok &&
               (((la[31:24] ^ base) & ~mask) == 8'h00);

endmodule

// ---- core/translation_unit.sv ----
// Translation cache and transparent windows of one memory unit
//
// Overview of operation
// - Sixty-four translations held in four ways of sixteen sets.
// - Cache mode codes: 00 write-through, 01 copyback, 10/11 noncachable.
// - Privilege tag bit is one for supervisor entries, zero for user.
// - Nonglobal-only flushes leave global entries untouched.
// - 4K pages compare all tag bits; 8K pages ignore the lowest.
// - Write to clean entry: abort, search setting modified, refill, retry.
// - Resident bit set only after a search without nonresident or error.
// - Supervisor-protected entries refuse user accesses.
// - User attribute bits go to the attribute pins, not translation.
// - Valid set on load, cleared by a selecting flush or flush-all.
// - Write-protect from search; writes hitting it fault at once.
// - Set index is the four address bits above the page offset.
// - Tags compare upper address bits and privilege; hit gives address.
// - Miss aborts, searches tables, stores translation, access retried.
// - Physical bit 12 from entry on 4K pages, from logical on 8K.
// - Fill an invalid way, else the way a 2-bit access counter names.
// - Lookup runs beside cache indexing; a hit adds no cycles.
// - Two windows per unit, each can be disabled, may overlap.
// - Window match: privilege select and unmasked top eight bits.
// - Writes are aborted when the governing matching window is write-protected.
// - Either window matching translates transparently; window zero wins.
// - Windows beat the cache; matching addresses pass unchanged.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
module translation_unit
  import mmu_pkg::*;
(
  // Clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Access request from the memory unit
  input  logic        req_valid,
  input  req_s        req,
  output logic        req_ready,
  // Answer to the memory unit and cache controller
  output resp_s       resp,
  output logic        user_attr_pin0,
  output logic        user_attr_pin1,
  // Table search engine
  output logic        walk_req,
  output logic [31:0] walk_la,
  output logic        walk_super,
  output logic        walk_set_m,
  input  logic        walk_done,
  input  desc_s       walk_desc,
  // Flush requests
  input  logic        flush_valid,
  input  logic        flush_all,
  input  logic        flush_nonglobal,
  input  logic [31:0] flush_la,
  input  logic        flush_super,
  output logic        flush_ack
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    entry_s [WAYS-1:0][SETS-1:0] translation_cache;
    state_e                      state;
    logic [1:0]                  repl;
    logic                        en;
    logic                        pg8k;
    logic [31:0]                 win0;
    logic [31:0]                 win1;
    logic                        last_fault;
    logic                        last_miss;
    logic [1:0]                  fill_way;
    logic                        set_m;
    logic [31:0]                 wla;
    logic                        wsuper;
    logic                        req_ready;
    resp_s                       resp;
    logic [1:0]                  upa;
    logic                        flush_ack;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
  } state_s;

  state_s q;
  state_s next_q;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Set index above the page offset
  function automatic logic [IDX_W-1:0] set_index(input logic [31:0] la,
                                                 input logic        pg8k);
    set_index = pg8k ? la[IDX8K_LO +: IDX_W]
                     : la[IDX4K_LO +: IDX_W];
  endfunction

  // Tag compare of one entry against an address and privilege
  function automatic logic tag_hit(input entry_s      e,
                                   input logic [31:0] la,
                                   input logic        supervisor,
                                   input logic        pg8k);
    logic [TAG_W-1:0] ign;
    ign = pg8k ? {{(TAG_W-1){1'b0}}, 1'b1} : '0;
    tag_hit = e.valid && (e.privilege_tag_bit == supervisor) &&
              (((e.la_tag ^ la[TAG_LO +: TAG_W]) & ~ign) == '0);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Transparent windows

  logic w0_hit;
  logic w1_hit;

  window_match u_win0 (
    .la         (req.la),
    .supervisor (req.supervisor),
    .win        (q.win0),
    .hit        (w0_hit)
  );

  window_match u_win1 (
    .la         (req.la),
    .supervisor (req.supervisor),
    .win        (q.win1),
    .hit        (w1_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] fidx;
    logic             hit;
    logic [1:0]       hway;
    logic             has_inv;
    logic [1:0]       inv_way;
    logic             wr;
    logic [31:0]      win;
    entry_s           e;
    entry_s           ne;
    idx     = '0;
    fidx    = '0;
    hit     = 1'b0;
    hway    = 2'h0;
    has_inv = 1'b0;
    inv_way = 2'h0;
    wr      = 1'b0;
    win     = '0;
    e       = '0;
    ne      = '0;
    next_q  = q;

    // One-cycle pulses fall by default
    next_q.resp.valid = 1'b0;
    next_q.flush_ack  = 1'b0;
    next_q.pready     = 1'b0;
    next_q.pslverr    = 1'b0;

    // APB: answer prepared in setup, write done in access phase
    if (psel && !penable) begin
      next_q.pready = 1'b1;
      unique case (paddr)
        ADDR_CTRL: next_q.prdata = {30'h0, q.pg8k, q.en};
        ADDR_WIN0: next_q.prdata = q.win0;
        ADDR_WIN1: next_q.prdata = q.win1;
        ADDR_STAT: next_q.prdata = {26'h0, q.repl, 1'b0, q.last_miss,
                                    q.last_fault, q.state == ST_WALK};
        default: begin
          next_q.prdata  = '0;
          next_q.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && q.pready && pwrite && !q.pslverr) begin
      unique case (paddr)
        ADDR_CTRL: begin
          next_q.en   = pwdata[CTRL_EN];
          next_q.pg8k = pwdata[CTRL_PG8K];
        end
        ADDR_WIN0: next_q.win0 = pwdata;
        ADDR_WIN1: next_q.win1 = pwdata;
        default: ;
      endcase
    end

    // Lookup of the indexed set in all four ways at once
    idx = set_index(req.la, q.pg8k);
    for (int w = 0; w < WAYS; w++) begin
      if (tag_hit(q.translation_cache[w][idx], req.la, req.supervisor, q.pg8k)) begin
        hit  = 1'b1;
        hway = 2'(w);
      end
      if (!q.translation_cache[w][idx].valid && !has_inv) begin
        has_inv = 1'b1;
        inv_way = 2'(w);
      end
    end
    e  = q.translation_cache[hway][idx];
    wr = req.write || req.rmw;

    unique case (q.state)
      ST_IDLE: begin
        if (req_valid) begin
          next_q.resp.valid       = 1'b1;
          next_q.resp.ok          = 1'b0;
          next_q.resp.retry       = 1'b0;
          next_q.resp.fault       = 1'b0;
          next_q.resp.transparent = 1'b0;
          next_q.resp.pa          = req.la;
          next_q.resp.cm          = CM_WT;
          next_q.upa              = 2'b00;
          next_q.last_miss        = 1'b0;
          if (w0_hit || w1_hit) begin
            // Window zero governs when both match
            win = w0_hit ? q.win0 : q.win1;
            next_q.resp.transparent = 1'b1;
            if (wr && win[WIN_WP]) begin
              next_q.resp.fault = 1'b1;
            end else begin
              next_q.resp.ok = 1'b1;
              next_q.resp.cm = cache_mode_e'(win[WIN_CM_LO +: 2]);
              next_q.upa     = win[WIN_U_LO +: 2];
            end
          end else if (!q.en) begin
            // Translation off: pass through with zero attributes
            next_q.resp.ok = 1'b1;
          end else begin
            next_q.repl = 2'(q.repl + 2'h1);
            if (hit) begin
              if (!e.r || (e.s && !req.supervisor) || (wr && e.w)) begin
                next_q.resp.fault = 1'b1;
              end else if (wr && !e.m) begin
                // Clean page: search again to set modified
                next_q.resp.retry = 1'b1;
                next_q.set_m      = 1'b1;
                next_q.fill_way   = hway;
                next_q.state      = ST_WALK;
              end else begin
                next_q.resp.ok = 1'b1;
                next_q.resp.cm = e.cache_mode_field;
                next_q.resp.pa = q.pg8k ?
                  {e.pa[PA_W-1:1], req.la[LA12], req.la[OFF_W-1:0]} :
                  {e.pa, req.la[OFF_W-1:0]};
                next_q.upa = {e.user_attr_bit1, e.user_attr_bit0};
              end
            end else begin
              // Miss: abort and search the tables
              next_q.resp.retry = 1'b1;
              next_q.last_miss  = 1'b1;
              next_q.set_m      = 1'b0;
              next_q.fill_way   = has_inv ? inv_way : q.repl;
              next_q.state      = ST_WALK;
            end
            if (!hit || (wr && !e.m && e.r && !e.w &&
                         !(e.s && !req.supervisor))) begin
              next_q.wla    = req.la;
              next_q.wsuper = req.supervisor;
            end
          end
          next_q.last_fault = next_q.resp.fault;
        end else if (flush_valid) begin
          // Flush: all, nonglobal, or selected address
          fidx = set_index(flush_la, q.pg8k);
          for (int w = 0; w < WAYS; w++) begin
            for (int s = 0; s < SETS; s++) begin
              if ((flush_all || (IDX_W'(s) == fidx &&
                   tag_hit(q.translation_cache[w][s], flush_la, flush_super, q.pg8k))) &&
                  !(flush_nonglobal && q.translation_cache[w][s].is_global)) begin
                next_q.translation_cache[w][s].valid = 1'b0;
              end
            end
          end
          next_q.flush_ack = 1'b1;
        end
      end
      ST_WALK: begin
        if (walk_done) begin
          // Store the new or refreshed translation
          fidx                 = set_index(q.wla, q.pg8k);
          ne.valid             = 1'b1;
          ne.is_global         = walk_desc.g;
          ne.privilege_tag_bit = q.wsuper;
          ne.la_tag            = q.wla[TAG_LO +: TAG_W];
          ne.user_attr_bit1    = walk_desc.u1;
          ne.user_attr_bit0    = walk_desc.u0;
          ne.s                 = walk_desc.s;
          ne.cache_mode_field  = walk_desc.cm;
          ne.m                 = walk_desc.m;
          ne.w                 = walk_desc.w;
          ne.r = !(walk_desc.nonres || walk_desc.terr);
          ne.pa                = walk_desc.pa;
          next_q.translation_cache[q.fill_way][fidx] = ne;
          next_q.state = ST_IDLE;
        end
      end
    endcase

    // Requests are taken only while idle
    next_q.req_ready = (next_q.state == ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.state     <= ST_IDLE;
      q.win0      <= RST_REG;
      q.win1      <= RST_REG;
      q.req_ready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state

  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign req_ready      = q.req_ready;
  assign resp           = q.resp;
  assign user_attr_pin0 = q.upa[0];
  assign user_attr_pin1 = q.upa[1];
  assign walk_req       = (q.state == ST_WALK);
  assign walk_la        = q.wla;
  assign walk_super     = q.wsuper;
  assign walk_set_m     = q.set_m;
  assign flush_ack      = q.flush_ack;

endmodule

// ---- testbench/walk_model.sv ----
// Table-search engine model answering translation walks
`timescale 1ns/1ns
module walk_model
  import mmu_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Search request
  input  wire logic        walk_req,
  input  wire logic [31:0] walk_la,
  input  wire logic        walk_set_m,
  // Answer shape and delay chosen by the bench
  input  wire desc_s       tmpl,
  input  wire logic [3:0]  lag,
  // Answer
  output logic             walk_done,
  output desc_s            walk_desc
);
  logic [3:0] cnt;

  // Answer lag+1 cycles after the request rises; outside the pulse the descriptor keeps changing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      walk_done <= 1'b0;
      walk_desc <= '0;
    end else if (walk_req && !walk_done && cnt == lag) begin
      cnt <= '0;
      walk_done <= 1'b1;
      walk_desc <= tmpl;
      walk_desc.pa <= walk_la[31:12] ^ 20'h0f0f1;
      walk_desc.m <= tmpl.m | walk_set_m;
    end else begin
      cnt <= (walk_req && !walk_done) ? cnt + 4'h1 : 4'h0;
      walk_done <= 1'b0;
      walk_desc <= ~walk_desc;
    end
  end
endmodule

// ---- testbench/translation_unit_properties.sv ----
// Port-level properties of the translation unit
`timescale 1ns/1ns
module translation_unit_properties
  import mmu_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Access and answer
  input wire logic        req_valid,
  input wire req_s        req,
  input wire logic        req_ready,
  input wire resp_s       resp,
  input wire logic        user_attr_pin0,
  input wire logic        user_attr_pin1,
  // Search and flush
  input wire logic        walk_req,
  input wire logic [31:0] walk_la,
  input wire logic        walk_done,
  input wire logic        flush_valid,
  input wire logic        flush_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // Access answers
  property p_answer_next;
    req_valid && req_ready |=> resp.valid;
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("no answer after accepted access");
  property p_no_stray;
    !(req_valid && req_ready) |=> !resp.valid;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("answer without access");
  property p_one_kind;
    resp.valid |-> $onehot({resp.ok, resp.retry, resp.fault});
  endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("answer kind not unique");
  property p_retry_walks;
    resp.valid && resp.retry |-> walk_req && !req_ready;
  endproperty
  a_retry_walks: assert property (p_retry_walks)
    else $error("retry without search");
  property p_window_pass;
    resp.valid && resp.ok && resp.transparent |-> resp.pa == $past(req.la);
  endproperty
  a_window_pass: assert property (p_window_pass)
    else $error("window address altered");
  property p_attr_quiet;
    resp.valid && !resp.ok |-> !user_attr_pin0 && !user_attr_pin1;
  endproperty
  a_attr_quiet: assert property (p_attr_quiet)
    else $error("attribute pins set on refused access");

  ////////////////////////////////////////
  // Search, flush and bus handshakes
  property p_walk_holds;
    walk_req && !walk_done |=> walk_req && $stable(walk_la);
  endproperty
  a_walk_holds: assert property (p_walk_holds)
    else $error("search request dropped early");
  property p_walk_ends;
    walk_req && walk_done |=> !walk_req && req_ready;
  endproperty
  a_walk_ends: assert property (p_walk_ends)
    else $error("search not closed after done");
  property p_flush_ack;
    flush_ack |-> $past(flush_valid);
  endproperty
  a_flush_ack: assert property (p_flush_ack)
    else $error("flush ack without request");
  property p_bus_ready;
    psel && !penable |=> pready;
  endproperty
  a_bus_ready: assert property (p_bus_ready)
    else $error("no ready after setup");
endmodule

bind translation_unit translation_unit_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .resp(resp), .user_attr_pin0(user_attr_pin0),
  .user_attr_pin1(user_attr_pin1), .walk_req(walk_req),
  .walk_la(walk_la), .walk_done(walk_done), .flush_valid(flush_valid),
  .flush_ack(flush_ack));

// ---- testbench/translation_unit_bench.sv ----
// Self-checking bench of the translation unit
`timescale 1ns/1ns
module translation_unit_bench;
  import mmu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, walk_la, flush_la;
  logic        req_valid, req_ready, user_attr_pin0, user_attr_pin1;
  logic        walk_req, walk_super, walk_set_m, walk_done, wr, fr;
  logic        flush_valid, flush_all, flush_nonglobal, flush_super;
  logic        flush_ack;
  logic [3:0]  lag;
  logic [1:0]  c;
  req_s        req;
  resp_s       resp, r;
  desc_s       walk_desc, tmpl;
  int          bad_count, total_checks;

  translation_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp(resp),
    .user_attr_pin0(user_attr_pin0), .user_attr_pin1(user_attr_pin1),
    .walk_req(walk_req), .walk_la(walk_la), .walk_super(walk_super),
    .walk_set_m(walk_set_m), .walk_done(walk_done), .walk_desc(walk_desc),
    .flush_valid(flush_valid), .flush_all(flush_all),
    .flush_nonglobal(flush_nonglobal), .flush_la(flush_la),
    .flush_super(flush_super), .flush_ack(flush_ack));
  walk_model partner (.pclk(pclk), .presetn(presetn), .walk_req(walk_req),
    .walk_la(walk_la), .walk_set_m(walk_set_m), .tmpl(tmpl), .lag(lag),
    .walk_done(walk_done), .walk_desc(walk_desc));

  ////////////////////////////////////////
  // Clock, watchdog and shared tasks
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus transfer held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One access; the answer is sampled one cycle after it is taken
  task automatic acc(input logic [31:0] la, input logic s, w, m);
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= '{la: la, supervisor: s, write: w, rmw: m};
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge pclk);
    r = resp;
  endtask
  // Access repeated once after a retry, as the memory unit does
  task automatic tr(input logic [31:0] la, input logic s, w, m);
    acc(la, s, w, m);
    wr = walk_set_m;
    fr = r.retry;
    if (r.retry === 1'b1)
      acc(la, s, w, m);
  endtask
  task automatic fl(input logic a, g, input logic [31:0] la);
    @(posedge pclk);
    flush_valid <= 1'b1;
    flush_all <= a;
    flush_nonglobal <= g;
    flush_la <= la;
    do @(posedge pclk); while (flush_ack !== 1'b1);
    flush_valid <= 1'b0;
  endtask
  // Fields: u1 u0 s cm[1:0] m w g nonresident
  function automatic desc_s td(input logic [8:0] f);
    td = desc_s'({20'h0, f, 1'b0});
  endfunction
  function automatic logic [31:0] xp(input logic [31:0] la, input logic k8);
    xp = la ^ 32'h0f0f_1000;
    if (k8)
      xp[12] = la[12];
  endfunction

  ////////////////////////////////////////
  // Test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req_valid, req} = '0;
    {flush_valid, flush_all, flush_nonglobal, flush_la} = '0;
    flush_super = 1'b1;
    tmpl = '0;
    lag = 4'h2;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_WIN0, 32'h0);
    check("win0 reset", rd, RST_REG);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", er, 1'b1);
    tr(32'h1234_5678, 1'b1, 1'b0, 1'b0);
    check("off pass", {r.ok, r.pa, r.cm}, {1'b1, 32'h1234_5678, CM_WT});
    fl(1'b1, 1'b0, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      tmpl <= td({i[1:0], 1'b0, i[1:0], 4'b1000});
      tr(32'h0040_0000 + (i << 16), 1'b1, 1'b0, 1'b0);
      check("miss first", fr, 1'b1);
      check("mode", r.cm, i[1:0]);
      check("pa", r.pa, xp(32'h0040_0000 + (i << 16), 1'b0));
      check("upa", {user_attr_pin1, user_attr_pin0}, i[1:0]);
    end
    for (int i = 0; i < 4; i++) begin
      tr(32'h0040_0000 + (i << 16), 1'b1, 1'b0, 1'b0);
      check("full set hit", fr, 1'b0);
    end
    apb(1'b0, ADDR_STAT, 32'h0);
    c = rd[5:4];
    tr(32'h0040_0000, 1'b1, 1'b0, 1'b0);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("counter", rd[5:4], 2'(c + 2'h1));
    tr(32'h0044_0000, 1'b1, 1'b0, 1'b0);
    tr(32'h0040_0000 + (rd[5:4] << 16), 1'b1, 1'b0, 1'b0);
    check("victim", fr, 1'b1);
    tmpl <= td(9'b0_0000_0000);
    tr(32'h0050_1000, 1'b1, 1'b0, 1'b0);
    tr(32'h0050_1000, 1'b1, 1'b1, 1'b0);
    check("clean write", {fr, wr, r.ok}, 3'b111);
    tr(32'h0050_1000, 1'b1, 1'b1, 1'b0);
    check("dirty write", {fr, r.ok}, 2'b01);
    tmpl <= td(9'b0_0000_1100);
    tr(32'h0060_2000, 1'b1, 1'b0, 1'b1);
    check("wp rmw", r.fault, 1'b1);
    acc(32'h0060_2000, 1'b1, 1'b1, 1'b0);
    check("wp write", r.fault, 1'b1);
    acc(32'h0060_2000, 1'b1, 1'b0, 1'b0);
    check("wp read", r.ok, 1'b1);
    tmpl <= td(9'b0_0100_1000);
    tr(32'h0070_3000, 1'b0, 1'b0, 1'b0);
    check("user on super page", r.fault, 1'b1);
    check("walk priv", walk_super, 1'b0);
    tr(32'h0070_3000, 1'b1, 1'b0, 1'b0);
    check("super entry apart", {fr, r.ok}, 2'b11);
    tmpl <= td(9'b0_0000_1001);
    tr(32'h0080_4000, 1'b1, 1'b0, 1'b0);
    check("nonresident", r.fault, 1'b1);
    tmpl <= td(9'b0_0000_1010);
    tr(32'h0090_5000, 1'b1, 1'b0, 1'b0);
    fl(1'b1, 1'b1, 32'h0);
    tr(32'h0090_5000, 1'b1, 1'b0, 1'b0);
    check("global kept", fr, 1'b0);
    fl(1'b0, 1'b0, 32'h0090_5000);
    tr(32'h0090_5000, 1'b1, 1'b0, 1'b0);
    check("single flush", fr, 1'b1);
    fl(1'b1, 1'b0, 32'h0);
    tr(32'h0090_5000, 1'b1, 1'b0, 1'b0);
    check("flush all", fr, 1'b1);
    tmpl <= td(9'b0_0000_1000);
    apb(1'b1, ADDR_CTRL, 32'h0);
    fl(1'b1, 1'b0, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h3);
    tr(32'h00a0_3000, 1'b1, 1'b0, 1'b0);
    check("8k pa", r.pa, xp(32'h00a0_3000, 1'b1));
    tr(32'h00a0_2000, 1'b1, 1'b0, 1'b0);
    check("8k same page", {fr, r.pa}, {1'b0, xp(32'h00a0_2000, 1'b1)});
    apb(1'b1, ADDR_WIN0, 32'h1200_c024);
    apb(1'b1, ADDR_WIN1, 32'h1200_c040);
    acc(32'h1234_0000, 1'b0, 1'b0, 1'b0);
    check("window", {r.transparent, r.pa}, {1'b1, 32'h1234_0000});
    check("window zero wins", r.cm, CM_CB);
    acc(32'h1234_0000, 1'b1, 1'b1, 1'b0);
    check("window wp", r.fault, 1'b1);
    apb(1'b1, ADDR_WIN0, 32'h0);
    acc(32'h1234_0000, 1'b1, 1'b1, 1'b0);
    check("win0 off", {r.ok, r.cm}, {1'b1, CM_NC_SER});
    apb(1'b1, ADDR_WIN1, 32'h300f_a040);
    acc(32'h3a00_0000, 1'b1, 1'b0, 1'b0);
    check("masked match", r.transparent, 1'b1);
    apb(1'b1, ADDR_WIN1, 32'h3000_8040);
    acc(32'h3000_0000, 1'b1, 1'b0, 1'b0);
    check("user window super", r.transparent, 1'b0);
    repeat (8) @(posedge pclk);
    acc(32'h3000_0000, 1'b0, 1'b0, 1'b0);
    check("user window user", r.transparent, 1'b1);
    report_and_stop;
  end
endmodule
